// File: design/afem_regs.vh
// Purpose: Constants for the alarm, fault and event monitor
// Assumes: 200 MHz aclk, 32-bit AXI4-Lite register bus
// Notes: Offsets are byte addresses of aligned words
`ifndef AFEM_REGS_VH
`define AFEM_REGS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AFEM_OFS_STATUS 8'h00
`define AFEM_OFS_CTRL 8'h04
`define AFEM_OFS_PSWD 8'h08
`define AFEM_OFS_PSWD_TRY 8'h0C
`define AFEM_OFS_CLOCK 8'h10
`define AFEM_OFS_LOG_PTR 8'h14
`define AFEM_OFS_LOG_DATA 8'h18
`define AFEM_OFS_LOG_STAMP 8'h1C
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define AFEM_CTRL_FRST 0
`define AFEM_CTRL_PEN 1
`define AFEM_CTRL_QSEL_LO 2
`define AFEM_CTRL_UP 4
`define AFEM_CTRL_DOWN 5
`define AFEM_CTRL_ENTER 6
`define AFEM_QSEL_RST 2'h2
`define AFEM_PSWD_RST 16'h1111
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define AFEM_CLK_HZ 200000000
`define AFEM_QUAL_S0 5'h03
`define AFEM_QUAL_S1 5'h0A
`define AFEM_QUAL_S2 5'h1E
`define AFEM_LBS_S 5'h03
`define AFEM_LBD_S 5'h0A
`endif

// File: design/afem_monitor.v
// Purpose: Alarm, fault and event supervision of a battery backup unit
// Assumes: Sense flags synchronous to aclk; AXI4-Lite master well behaved
// Notes: Event log is a circular buffer of time-stamped 16-bit vectors
`default_nettype none
`include "afem_regs.vh"
module afem_monitor #(
  parameter CLK_HZ = `AFEM_CLK_HZ,
  parameter LOG_AW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire in_high,
  input wire in_low,
  input wire blackout,
  input wire overload,
  input wire batt_temp_high,
  input wire int_temp_high,
  input wire batt_high_volt,
  input wire batt_low_volt,
  input wire load_short,
  input wire inv_start_fail,
  input wire batt_low,
  input wire freq_low,
  input wire freq_high,
  input wire input_failure,
  input wire batt_temp_range,
  input wire probe_missing,
  input wire batt_not_conn,
  input wire ext_alarm,
  input wire batt_alarm,
  input wire fan_fail,
  input wire door_open,
  input wire batt_at_425,
  input wire batt_at_40,
  input wire line_ok,
  output reg alarm_led,
  output reg alarm_contact,
  output reg charger_lowest,
  output reg output_on,
  output reg line_mode,
  output reg batt_mode,
  output reg bypass_mode,
  output reg low_batt_warn,
  output reg sleep_mode,
  output reg batt_disconnect,
  output reg panel_off,
  output reg show_alarm,
  output reg show_fault,
  output reg maint_access
);
  // ------------------------------------------------------------
  // Constants and functions
  // ------------------------------------------------------------
  localparam [31:0] TICK_FULL = CLK_HZ - 1;
  localparam [27:0] TICK_CYC = TICK_FULL[27:0];
  localparam [2:0] ST_LINE = 3'h1;
  localparam [2:0] ST_BATT = 3'h2;
  localparam [2:0] ST_OFF = 3'h4;
  localparam LOG_N = 1 << LOG_AW;
  localparam [LOG_AW-1:0] PTR_ONE = {{(LOG_AW-1){1'b0}}, 1'b1};
  localparam [LOG_AW:0] CNT_ONE = {{LOG_AW{1'b0}}, 1'b1};
  localparam [LOG_AW:0] CNT_FULL = {1'b1, {LOG_AW{1'b0}}};

  function [4:0] afem_qual_s;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: afem_qual_s = `AFEM_QUAL_S0;
        2'h1: afem_qual_s = `AFEM_QUAL_S1;
        default: afem_qual_s = `AFEM_QUAL_S2;
      endcase
    end
  endfunction

  function [4:0] afem_sat;
    input [4:0] cnt;
    input cond;
    begin
      if (!cond)
        afem_sat = 5'h00;
      else if (cnt == 5'h1F)
        afem_sat = cnt;
      else
        afem_sat = cnt + 5'h01;
    end
  endfunction

  // ------------------------------------------------------------
  // Seconds tick and wall clock
  // ------------------------------------------------------------
  reg [27:0] tick_cnt_ff;
  reg tick_ff;
  reg [31:0] clock_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_ff <= 28'h0000000;
      tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff == TICK_CYC)
    begin
      tick_cnt_ff <= 28'h0000000;
      tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 28'h0000001;
      tick_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Conditions, latches and event vector
  // ------------------------------------------------------------
  wire short_cond = load_short | inv_start_fail;
  wire temp_cond = batt_temp_high | int_temp_high;
  wire freq_alarm = freq_low | freq_high;
  wire ext_group = ext_alarm | batt_alarm | fan_fail | door_open;
  reg short_lat_ff, hv_lat_ff, ol_lat_ff;
  reg frst_ff;
  // Set beats clear so a fault during reset command is kept
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      short_lat_ff <= 1'b0;
      hv_lat_ff <= 1'b0;
      ol_lat_ff <= 1'b0;
    end
    else
    begin
      short_lat_ff <= short_cond | (short_lat_ff & ~frst_ff);
      hv_lat_ff <= batt_high_volt | (hv_lat_ff & ~frst_ff);
      ol_lat_ff <= overload | (ol_lat_ff & ~frst_ff);
    end
  end
  // Low battery and temperature faults follow the condition live
  wire fault_any = short_lat_ff | hv_lat_ff | ol_lat_ff |
    batt_low_volt | temp_cond;
  wire alarm_any = freq_alarm | probe_missing | batt_not_conn |
    batt_temp_range | ext_group | batt_low;
  // Bit 0 is position 1; bit 12 is the reserved position 13
  wire [15:0] evt_vec = {batt_not_conn, probe_missing, batt_temp_range,
    1'b0, input_failure, freq_high, freq_low, batt_low,
    short_cond, batt_low_volt, batt_high_volt, temp_cond,
    overload, blackout, in_low, in_high};

  // ------------------------------------------------------------
  // Duration qualification
  // ------------------------------------------------------------
  reg [4:0] q_cnt_ff, lbs_cnt_ff, lbd_cnt_ff;
  reg [1:0] qsel_ff;
  reg [2:0] st_ff;
  wire line_qual = q_cnt_ff >= afem_qual_s(qsel_ff);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_cnt_ff <= 5'h00;
      lbs_cnt_ff <= 5'h00;
      lbd_cnt_ff <= 5'h00;
    end
    else
    begin
      if (!line_ok)
        q_cnt_ff <= 5'h00;
      else if (tick_ff)
        q_cnt_ff <= afem_sat(q_cnt_ff, 1'b1);
      if (!batt_at_425)
        lbs_cnt_ff <= 5'h00;
      else if (tick_ff)
        lbs_cnt_ff <= afem_sat(lbs_cnt_ff, 1'b1);
      if (!batt_at_40)
        lbd_cnt_ff <= 5'h00;
      else if (tick_ff)
        lbd_cnt_ff <= afem_sat(lbd_cnt_ff, 1'b1);
    end
  end
  wire lbs_hit = lbs_cnt_ff >= `AFEM_LBS_S;
  wire lbd_hit = lbd_cnt_ff >= `AFEM_LBD_S;

  // ------------------------------------------------------------
  // Operating mode
  // ------------------------------------------------------------
  reg [2:0] nxt_st;
  reg dark_ff;
  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_LINE:
        if (!line_ok)
          nxt_st = ST_BATT;
      ST_BATT:
        if (line_qual)
          nxt_st = ST_LINE;
        else if (lbs_hit)
          nxt_st = ST_OFF;
      ST_OFF:
        if (line_qual)
          nxt_st = ST_LINE;
      default:
        nxt_st = ST_BATT;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= ST_BATT;
      dark_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      // Fresh batteries show as 40V level dropping
      if (line_qual | ~batt_at_40)
        dark_ff <= 1'b0;
      else if (lbd_hit)
        dark_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers and keypad
  // ------------------------------------------------------------
  reg pen_ff, granted_ff;
  reg [15:0] pswd_ff;
  reg [31:0] nxt_clock;
  reg [LOG_AW-1:0] wr_ptr_ff, view_ptr_ff;
  reg [LOG_AW:0] count_ff;
  reg [15:0] log_vec [0:LOG_N-1];
  reg [31:0] log_stamp [0:LOG_N-1];
  reg [15:0] prev_vec_ff;
  reg [7:0] aw_ff;
  reg [31:0] w_ff;
  reg aw_ok_ff, w_ok_ff;
  wire wr_go = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
  wire log_new = |(evt_vec & ~prev_vec_ff);
  always @*
  begin
    nxt_clock = clock_ff;
    if (tick_ff)
      nxt_clock = clock_ff + 32'h00000001;
    if (wr_go && aw_ff == `AFEM_OFS_CLOCK)
      nxt_clock = w_ff;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_ff <= 8'h00;
      w_ff <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      frst_ff <= 1'b0;
      pen_ff <= 1'b0;
      granted_ff <= 1'b0;
      qsel_ff <= `AFEM_QSEL_RST;
      pswd_ff <= `AFEM_PSWD_RST;
      clock_ff <= 32'h00000000;
      view_ptr_ff <= {LOG_AW{1'b0}};
      show_alarm <= 1'b0;
      show_fault <= 1'b0;
    end
    else
    begin
      clock_ff <= nxt_clock;
      frst_ff <= 1'b0;
      s_axi_awready <= ~aw_ok_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_ok_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_ok_ff <= 1'b1;
        aw_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_ok_ff <= 1'b1;
        w_ff <= s_axi_wdata;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_ff > 8'h1F) ? 2'h2 : 2'h0;
        if (aw_ff == `AFEM_OFS_CTRL)
        begin
          frst_ff <= w_ff[`AFEM_CTRL_FRST];
          pen_ff <= w_ff[`AFEM_CTRL_PEN];
          if (w_ff[`AFEM_CTRL_QSEL_LO+1 -: 2] != 2'h3)
            qsel_ff <= w_ff[`AFEM_CTRL_QSEL_LO+1 -: 2];
          if (w_ff[`AFEM_CTRL_UP])
            view_ptr_ff <= view_ptr_ff + PTR_ONE;
          else if (w_ff[`AFEM_CTRL_DOWN])
            view_ptr_ff <= view_ptr_ff - PTR_ONE;
          show_alarm <= w_ff[`AFEM_CTRL_ENTER] & alarm_any &
            ~fault_any;
          show_fault <= w_ff[`AFEM_CTRL_ENTER] & fault_any;
        end
        if (aw_ff == `AFEM_OFS_PSWD && granted_ff)
          pswd_ff <= w_ff[15:0];
        if (aw_ff == `AFEM_OFS_PSWD_TRY)
          granted_ff <= (w_ff[15:0] == pswd_ff);
      end
    end
  end

  // ------------------------------------------------------------
  // Event log
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_ff <= {LOG_AW{1'b0}};
      count_ff <= {(LOG_AW+1){1'b0}};
      prev_vec_ff <= 16'h0000;
    end
    else
    begin
      prev_vec_ff <= evt_vec;
      if (log_new)
      begin
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
        if (count_ff != CNT_FULL)
          count_ff <= count_ff + CNT_ONE;
      end
    end
  end
  always @(posedge aclk)
  begin
    if (log_new)
    begin
      log_vec[wr_ptr_ff] <= evt_vec;
      log_stamp[wr_ptr_ff] <= clock_ff;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  reg [31:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = 32'h00000000;
    case (s_axi_araddr)
      `AFEM_OFS_STATUS: nxt_rdata = {11'h000, st_ff, fault_any,
        alarm_any, evt_vec};
      `AFEM_OFS_CTRL: nxt_rdata = {28'h0000000, qsel_ff, pen_ff, 1'b0};
      `AFEM_OFS_PSWD: nxt_rdata = {31'h00000000, granted_ff};
      `AFEM_OFS_CLOCK: nxt_rdata = clock_ff;
      `AFEM_OFS_LOG_PTR: nxt_rdata = {16'h0000, 3'h0, count_ff,
        4'h0, view_ptr_ff};
      `AFEM_OFS_LOG_DATA: nxt_rdata = {16'h0000, log_vec[view_ptr_ff]};
      `AFEM_OFS_LOG_STAMP: nxt_rdata = log_stamp[view_ptr_ff];
      default: nxt_rdata = 32'h00000000;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= (s_axi_araddr > 8'h1F) ? 2'h2 : 2'h0;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  reg flash_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_ff <= 1'b0;
      alarm_led <= 1'b0;
      alarm_contact <= 1'b0;
      charger_lowest <= 1'b0;
      output_on <= 1'b0;
      line_mode <= 1'b0;
      batt_mode <= 1'b0;
      bypass_mode <= 1'b0;
      low_batt_warn <= 1'b0;
      sleep_mode <= 1'b0;
      batt_disconnect <= 1'b0;
      panel_off <= 1'b0;
      maint_access <= 1'b0;
    end
    else
    begin
      if (tick_ff)
        flash_ff <= ~flash_ff;
      alarm_led <= ~dark_ff & (fault_any | (alarm_any & flash_ff));
      // above: steady on fault, flashing on alarm only
      alarm_contact <= ext_group;
      charger_lowest <= probe_missing;
      output_on <= (st_ff == ST_LINE) |
        ((st_ff == ST_BATT) & ~fault_any);
      line_mode <= (st_ff == ST_LINE) & ~fault_any;
      batt_mode <= (st_ff == ST_BATT) & ~fault_any;
      bypass_mode <= (st_ff == ST_LINE) & fault_any;
      low_batt_warn <= (st_ff == ST_BATT) & batt_low;
      sleep_mode <= (st_ff == ST_OFF);
      batt_disconnect <= dark_ff;
      panel_off <= dark_ff;
      maint_access <= ~pen_ff | granted_ff;
    end
  end
endmodule
`default_nettype wire

// File: tb/afem_sense_model.sv
// Purpose: Sensing stage model feeding comparator flags
// Assumes: Bench sets the wanted condition levels in cmd
// Notes: Flags lag one cycle, as a clocked comparator would
`default_nettype none
module afem_sense_model (
  input wire logic aclk,
  input wire logic [24:0] cmd,
  output logic [24:0] sv
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Comparator stage
  // ----------------------------------------
  // Registered so no flag changes near the sampling edge
  always @(posedge aclk)
    sv <= cmd;
endmodule
`default_nettype wire

// File: tb/afem_monitor_properties.sv
// Purpose: Port level checks of the event monitor
// Assumes: CLK_HZ equals the instance value; one clock
// Notes: Shutdown limits allow one second of tick jitter
`default_nettype none
module afem_monitor_props #(
  parameter int CLK_HZ = 200000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_alarm,
  input wire logic batt_alarm,
  input wire logic fan_fail,
  input wire logic door_open,
  input wire logic probe_missing,
  input wire logic batt_at_425,
  input wire logic batt_at_40,
  input wire logic alarm_contact,
  input wire logic charger_lowest,
  input wire logic sleep_mode,
  input wire logic output_on,
  input wire logic batt_disconnect,
  input wire logic panel_off,
  input wire logic alarm_led,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helper counters and properties
  // ----------------------------------------
  logic [31:0] n425_ff;
  logic [31:0] n40_ff;
  wire grp = ext_alarm | batt_alarm | fan_fail | door_open;
  always @(posedge aclk)
  begin
    n425_ff <= (!aresetn || !batt_at_425) ? 32'h0 : n425_ff + 32'h1;
    n40_ff <= (!aresetn || !batt_at_40) ? 32'h0 : n40_ff + 32'h1;
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_contact_on;
    grp |=> alarm_contact;
  endproperty
  a_contact_on: assert property (p_contact_on)
    else $error("contact open while group active");
  property p_contact_off;
    !grp |=> !alarm_contact;
  endproperty
  a_contact_off: assert property (p_contact_off)
    else $error("contact closed with group idle");
  property p_chg_low;
    $rose(probe_missing) |=> charger_lowest;
  endproperty
  a_chg_low: assert property (p_chg_low)
    else $error("charger not forced lowest");
  property p_sleep_min;
    $rose(sleep_mode) |-> n425_ff >= 2 * CLK_HZ;
  endproperty
  a_sleep_min: assert property (p_sleep_min)
    else $error("sleep entered too early");
  property p_sleep_out;
    $rose(sleep_mode) |-> ##[0:2] !output_on;
  endproperty
  a_sleep_out: assert property (p_sleep_out)
    else $error("output still on in sleep");
  property p_disc_min;
    $rose(batt_disconnect) |-> n40_ff >= 9 * CLK_HZ;
  endproperty
  a_disc_min: assert property (p_disc_min)
    else $error("battery dropped too early");
  property p_dark;
    $rose(batt_disconnect) |-> ##[0:2] (panel_off && !alarm_led);
  endproperty
  a_dark: assert property (p_dark)
    else $error("panel lit after disconnect");
  property p_rone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rone: assert property (p_rone)
    else $error("read answer repeated");
endmodule
bind afem_monitor afem_monitor_props #(.CLK_HZ(CLK_HZ)) u_props (
  .aclk, .aresetn, .ext_alarm, .batt_alarm, .fan_fail, .door_open,
  .probe_missing, .batt_at_425, .batt_at_40, .alarm_contact,
  .charger_lowest, .sleep_mode, .output_on, .batt_disconnect,
  .panel_off, .alarm_led, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// File: tb/afem_monitor_bench.sv
// Purpose: Self-checking bench of the event monitor
// Assumes: CLK_HZ cut to 20, so one second is 20 cycles
// Notes: Bus tasks sample at the falling edge, act at rising
`default_nettype none
`include "afem_regs.vh"
module afem_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int HZ = 20;
  localparam int FS [4] = '{6, 4, 16, 17};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d, e;
  logic [3:0] s_axi_wstrb;
  logic [24:0] cmd;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, alarm_led, alarm_contact;
  wire charger_lowest, output_on, line_mode, batt_mode, bypass_mode;
  wire low_batt_warn, sleep_mode, batt_disconnect, panel_off;
  wire show_alarm, show_fault, maint_access;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [24:0] sv;
  int errors, n_checks, cyc;
  afem_monitor #(.CLK_HZ(HZ)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .in_high(sv[0]), .in_low(sv[1]),
    .blackout(sv[2]), .overload(sv[3]), .batt_temp_high(sv[4]),
    .batt_high_volt(sv[5]), .batt_low_volt(sv[6]), .load_short(sv[7]),
    .batt_low(sv[8]), .freq_low(sv[9]), .freq_high(sv[10]),
    .input_failure(sv[11]), .batt_temp_range(sv[13]),
    .probe_missing(sv[14]), .batt_not_conn(sv[15]),
    .int_temp_high(sv[16]), .inv_start_fail(sv[17]),
    .ext_alarm(sv[18]), .batt_alarm(sv[19]), .fan_fail(sv[20]),
    .door_open(sv[21]), .batt_at_425(sv[22]), .batt_at_40(sv[23]),
    .line_ok(sv[24]), .alarm_led, .alarm_contact, .charger_lowest,
    .output_on, .line_mode, .batt_mode, .bypass_mode, .low_batt_warn,
    .sleep_mode, .batt_disconnect, .panel_off, .show_alarm,
    .show_fault, .maint_access);
  afem_sense_model u_sense (.aclk, .cmd, .sv);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task c1(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task w(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task put(input int i, input logic v);
    @(posedge aclk);
    cmd[i] <= v;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    logic ta, tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end while (!tv);
    s_axi_rready <= 1'b0;
  endtask
  task final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs();
    rd(`AFEM_OFS_CTRL, d);
    chk(d, 32'h8);
    rd(8'h20, d);
    chk({30'h0, rr}, 32'h2);
    wr(8'h40, 32'h0);
    chk({30'h0, rr}, 32'h2);
    c1(maint_access, 1'b1);
    wr(`AFEM_OFS_CTRL, 32'hA);
    wr(`AFEM_OFS_PSWD_TRY, 32'h1234);
    rd(`AFEM_OFS_PSWD, d);
    chk(d, 32'h0);
    c1(maint_access, 1'b0);
    wr(`AFEM_OFS_PSWD_TRY, 32'h1111);
    rd(`AFEM_OFS_PSWD, d);
    chk(d, 32'h1);
    wr(`AFEM_OFS_PSWD, 32'h2222);
    wr(`AFEM_OFS_PSWD_TRY, 32'h2222);
    rd(`AFEM_OFS_PSWD, d);
    chk(d, 32'h1);
    c1(maint_access, 1'b1);
    wr(`AFEM_OFS_CTRL, 32'h4);
    wr(`AFEM_OFS_CTRL, 32'hC);
    rd(`AFEM_OFS_CTRL, d);
    chk(d, 32'h4);
    wr(`AFEM_OFS_CTRL, 32'h8);
  endtask
  task t_log();
    wr(`AFEM_OFS_CLOCK, 32'h100);
    for (int p = 1; p < 3; p++)
    begin
      put(p, 1'b1);
      w(3);
      put(p, 1'b0);
      rd(`AFEM_OFS_LOG_PTR, e);
      chk({27'h0, e[12:8]}, p);
    end
    rd(`AFEM_OFS_LOG_DATA, d);
    chk(d, 32'h2);
    rd(`AFEM_OFS_LOG_STAMP, d);
    chk({8'h0, d[31:8]}, 32'h1);
    wr(`AFEM_OFS_CTRL, 32'h18);
    rd(`AFEM_OFS_LOG_DATA, d);
    chk(d, 32'h4);
    wr(`AFEM_OFS_CTRL, 32'h28);
    rd(`AFEM_OFS_LOG_PTR, d);
    chk({28'h0, d[3:0]}, {28'h0, e[3:0]});
    wr(`AFEM_OFS_CTRL, 32'h28);
    rd(`AFEM_OFS_LOG_PTR, d);
    chk({28'h0, d[3:0]}, {28'h0, e[3:0] - 4'h1});
  endtask
  task t_vec();
    for (int p = 0; p < 22; p++)
    begin
      if (p == 12 || p == 16 || p == 17)
        continue;
      put(p, 1'b1);
      w(3);
      rd(`AFEM_OFS_STATUS, d);
      chk({16'h0, d[15:0]}, p < 16 ? 32'h1 << p : 32'h0);
      c1(alarm_contact, p > 17);
      put(p, 1'b0);
      wr(`AFEM_OFS_CTRL, 32'h9);
    end
  endtask
  task t_fault();
    put(7, 1'b1);
    w(3);
    put(7, 1'b0);
    repeat (4)
    begin
      w(HZ / 2);
      c1(alarm_led, 1'b1);
    end
    wr(`AFEM_OFS_CTRL, 32'h48);
    w(2);
    c1(show_fault, 1'b1);
    c1(show_alarm, 1'b0);
    wr(`AFEM_OFS_CTRL, 32'h9);
    for (int i = 0; i < 4; i++)
    begin
      put(FS[i], 1'b1);
      w(3);
      rd(`AFEM_OFS_STATUS, d);
      chk({31'h0, d[17]}, 32'h1);
      put(FS[i], 1'b0);
      w(3);
      rd(`AFEM_OFS_STATUS, d);
      chk({31'h0, d[17]}, {31'h0, i == 3});
      wr(`AFEM_OFS_CTRL, 32'h9);
    end
    rd(`AFEM_OFS_STATUS, d);
    chk({31'h0, d[17]}, 32'h0);
    put(5, 1'b1);
    w(3);
    put(5, 1'b0);
    rd(`AFEM_OFS_STATUS, d);
    chk({31'h0, d[17]}, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`AFEM_OFS_STATUS, d);
    chk({31'h0, d[17]}, 32'h0);
  endtask
  task t_alarm();
    put(10, 1'b1);
    put(14, 1'b1);
    w(3);
    c1(charger_lowest, 1'b1);
    rd(`AFEM_OFS_STATUS, d);
    chk({30'h0, d[17:16]}, 32'h1);
    w(0);
    e[0] = alarm_led;
    w(HZ);
    c1(alarm_led, ~e[0]);
    c1(output_on, 1'b1);
    wr(`AFEM_OFS_CTRL, 32'h48);
    w(2);
    c1(show_alarm, 1'b1);
    c1(show_fault, 1'b0);
    put(10, 1'b0);
    put(14, 1'b0);
    w(3);
    rd(`AFEM_OFS_STATUS, d);
    chk({31'h0, d[16]}, 32'h0);
    c1(batt_mode, 1'b1);
    c1(charger_lowest, 1'b0);
  endtask
  task t_line();
    wr(`AFEM_OFS_CTRL, 32'h0);
    put(24, 1'b1);
    w(2 * HZ - 4);
    c1(line_mode, 1'b0);
    w(HZ + 12);
    c1(line_mode, 1'b1);
    put(7, 1'b1);
    w(3);
    put(7, 1'b0);
    w(3);
    c1(bypass_mode, 1'b1);
    c1(output_on, 1'b1);
    c1(line_mode, 1'b0);
    put(24, 1'b0);
    wr(`AFEM_OFS_CTRL, 32'h9);
  endtask
  task t_lowb();
    put(8, 1'b1);
    w(3);
    c1(low_batt_warn, 1'b1);
    c1(output_on, 1'b1);
    put(22, 1'b1);
    w(2 * HZ - 4);
    c1(sleep_mode, 1'b0);
    w(HZ + 12);
    c1(sleep_mode, 1'b1);
    c1(output_on, 1'b0);
    put(23, 1'b1);
    w(11 * HZ + 8);
    c1(batt_disconnect, 1'b1);
    c1(panel_off, 1'b1);
    c1(alarm_led, 1'b0);
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      errors++;
      final_report();
    end
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    cmd = 25'h0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_log();
    t_vec();
    t_fault();
    t_alarm();
    t_line();
    t_lowb();
    final_report();
  end
endmodule
`default_nettype wire
